// [hw/uc_pkg.sv]
// Shared constants, codes and parity helper for the serial port.
// Functional notes
// - Global, transmit and receive enable bits
// - Infrared enable plus low power sub-mode
// - Clearing both infrared bits restores NRZ
// - Word length five to eight bits
// - One or two stop bits
// - Five parity modes, sent and checked
// - Bit rate divided from module clock
// - Line settings read back as written
// - Receive data available flag
// - Transmit full flag; writer holds off
// - Independent receive and transmit DMA enables
// - Receive DMA stops on error if enabled
// - Receive FIFO 16x12, transmit 16x8
// - Rates from stopped up to clock/16
// - Framing bits added and stripped
package uc_pkg;
  localparam int          CLK_HZ        = 50000000;
  localparam logic [4:0]  OFS_DATA      = 5'h00;
  localparam logic [4:0]  OFS_CTRL      = 5'h04;
  localparam logic [4:0]  OFS_LINE      = 5'h08;
  localparam logic [4:0]  OFS_BAUD      = 5'h0c;
  localparam logic [4:0]  OFS_STAT      = 5'h10;
  localparam logic [4:0]  OFS_INTS      = 5'h14;
  localparam logic [4:0]  OFS_MASK      = 5'h18;
  localparam int          CB_GLOBAL     = 0;
  localparam int          CB_TXEN       = 1;
  localparam int          CB_RXEN       = 2;
  localparam int          CB_FIFOEN     = 3;
  localparam int          CB_IREN       = 4;
  localparam int          CB_IRLP       = 5;
  localparam int          CB_DMARX      = 6;
  localparam int          CB_DMATX      = 7;
  localparam int          CB_ERRSTOP    = 8;
  localparam int          CB_FLUSH      = 9;
  localparam logic [8:0]  CTRL_RST      = 9'h000;
  localparam logic [5:0]  LINE_RST      = 6'h03;
  localparam logic [15:0] BAUD_RST      = 16'h0000;
  localparam int          EV_RX         = 0;
  localparam int          EV_TXEMPTY    = 1;
  localparam int          EV_PARERR     = 2;
  localparam int          EV_FRMERR     = 3;
  localparam int          EV_OVERRUN    = 4;
  localparam logic [1:0]  word_length_five  = 2'h0;
  localparam logic [1:0]  word_length_eight = 2'h3;
  localparam logic [2:0]  parity_off         = 3'h0;
  localparam logic [2:0]  parity_even_sel    = 3'h1;
  localparam logic [2:0]  parity_odd_sel     = 3'h2;
  localparam logic [2:0]  parity_forced_high = 3'h3;
  localparam logic [2:0]  parity_forced_low  = 3'h4;
  localparam logic [3:0]  TICK_LAST     = 4'hf;
  localparam logic [3:0]  TICK_MID      = 4'h7;
  localparam logic [3:0]  IR_PULSE_END  = 4'h9;
  localparam logic [3:0]  IR_HOLD_TICKS = 4'hf;

  // Parity over the active data bits only; forced modes ignore data.
  function automatic logic uc_parity(input logic [7:0] d,
                                     input logic [1:0] wl,
                                     input logic [2:0] mode);
    logic [7:0] m;
    m = 8'hff >> (2'd3 - wl);
    case (mode)
      parity_even_sel:    return ^(d & m);
      parity_odd_sel:     return ~^(d & m);
      parity_forced_high: return 1'b1;
      default:            return 1'b0;
    endcase
  endfunction
endpackage

// [hw/uc_tx.sv]
// Transmit serializer: start, data LSB first, parity, stop bits.
`timescale 1ns/1ns
module uc_tx import uc_pkg::*; (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic [7:0] data,
  input  wire logic [1:0] wlen,
  input  wire logic       stop_two,
  input  wire logic [2:0] parity,
  output logic            busy,
  output logic            txd,
  output logic [3:0]      phase
);
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP}
    uc_tx_state_t;
  uc_tx_state_t state_reg;
  logic [7:0]   sh_reg;
  logic [3:0]   cnt_reg;
  logic [2:0]   bit_reg;
  logic [1:0]   wl_reg;
  logic         par_reg, paron_reg, two_reg, txd_reg;
  wire          bit_end = tick && (cnt_reg == TICK_LAST);

  // Settings are captured at start so a frame never changes shape.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_reg <= S_IDLE;
      txd_reg   <= 1'b1;
      sh_reg    <= 8'h00;
      cnt_reg   <= 4'h0;
      bit_reg   <= 3'h0;
      wl_reg    <= 2'h0;
      par_reg   <= 1'b0;
      paron_reg <= 1'b0;
      two_reg   <= 1'b0;
    end else begin
      if (tick) cnt_reg <= cnt_reg + 4'h1;
      case (state_reg)
        S_IDLE: if (start) begin
          sh_reg    <= data;
          wl_reg    <= wlen;
          par_reg   <= uc_parity(data, wlen, parity);
          paron_reg <= (parity != parity_off);
          two_reg   <= stop_two;
          cnt_reg   <= 4'h0;
          txd_reg   <= 1'b0;
          state_reg <= S_START;
        end
        S_START: if (bit_end) begin
          txd_reg   <= sh_reg[0];
          bit_reg   <= 3'h0;
          state_reg <= S_DATA;
        end
        S_DATA: if (bit_end) begin
          sh_reg  <= sh_reg >> 1;
          bit_reg <= bit_reg + 3'h1;
          txd_reg <= sh_reg[1];
          if (bit_reg == {1'b1, wl_reg}) begin
            txd_reg   <= paron_reg ? par_reg : 1'b1;
            bit_reg   <= 3'h0;
            state_reg <= paron_reg ? S_PAR : S_STOP;
          end
        end
        S_PAR: if (bit_end) begin
          txd_reg   <= 1'b1;
          state_reg <= S_STOP;
        end
        S_STOP: if (bit_end) begin
          bit_reg <= 3'h1;
          if (!two_reg || bit_reg != 3'h0) state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  assign busy  = (state_reg != S_IDLE);
  assign txd   = txd_reg;
  assign phase = cnt_reg;
endmodule // uc_tx

// [hw/uc_rx.sv]
// Receive sampler: finds start, samples mid-bit, checks parity/stop.
`timescale 1ns/1ns
module uc_rx import uc_pkg::*; (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       tick,
  input  wire logic       enable,
  input  wire logic       rxd,
  input  wire logic [1:0] wlen,
  input  wire logic [2:0] parity,
  output logic            done,
  output logic [7:0]      data,
  output logic            par_err,
  output logic            frame_err
);
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP}
    uc_rx_state_t;
  uc_rx_state_t state_reg;
  logic [7:0]   sh_reg, data_reg;
  logic [3:0]   cnt_reg;
  logic [2:0]   bit_reg;
  logic         pe_reg, fe_reg, done_reg;
  wire  [7:0]   aligned = sh_reg >> (2'd3 - wlen);
  wire          mid     = tick && (cnt_reg == TICK_LAST);

  // Framing bits are checked here and never reach the FIFO.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_reg <= S_IDLE;
      sh_reg    <= 8'h00;
      data_reg  <= 8'h00;
      cnt_reg   <= 4'h0;
      bit_reg   <= 3'h0;
      pe_reg    <= 1'b0;
      fe_reg    <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (tick) cnt_reg <= cnt_reg + 4'h1;
      case (state_reg)
        S_IDLE: if (!rxd) begin
          cnt_reg   <= 4'h0;
          state_reg <= S_START;
        end
        S_START: if (tick && cnt_reg == TICK_MID) begin
          cnt_reg   <= 4'h0;
          bit_reg   <= 3'h0;
          pe_reg    <= 1'b0;
          state_reg <= rxd ? S_IDLE : S_DATA; // Glitch, not a start.
        end
        S_DATA: if (mid) begin
          sh_reg  <= {rxd, sh_reg[7:1]};
          bit_reg <= bit_reg + 3'h1;
          if (bit_reg == {1'b1, wlen})
            state_reg <= (parity != parity_off) ? S_PAR : S_STOP;
        end
        S_PAR: if (mid) begin
          pe_reg    <= rxd ^ uc_parity(aligned, wlen, parity);
          state_reg <= S_STOP;
        end
        S_STOP: if (mid) begin
          fe_reg    <= !rxd;
          data_reg  <= aligned;
          done_reg  <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
      if (!enable) state_reg <= S_IDLE;
    end
  end

  assign done      = done_reg;
  assign data      = data_reg;
  assign par_err   = pe_reg;
  assign frame_err = fe_reg;
endmodule // uc_rx

// [hw/uc_uart.sv]
// Serial port top: registers, FIFOs, bit rate, infrared and DMA logic.
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
module uc_uart import uc_pkg::*; #(
  parameter int DEPTH        = 16,
  parameter int RX_W         = 12,
  parameter int TX_W         = 8,
  parameter int IR_LP_CYCLES = 8
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        serial_rxd,
  input  wire logic        ir_rxd,
  output logic             serial_txd,
  output logic             ir_txd,
  output logic             rx_dma_req,
  output logic             tx_dma_req,
  output logic             irq
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
  localparam logic [PW:0] ONE_C   = (PW+1)'(1);

  // Pointer wrap shared by both FIFOs.
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  // ---- Control and configuration registers.
  logic [8:0]  ctrl_reg;
  logic [5:0]  line_reg;
  logic [15:0] baud_reg;
  logic [4:0]  ints_reg, mask_reg;
  logic        errseen_reg;
  logic [31:0] rdata_reg;

  wire port_en  = ctrl_reg[CB_GLOBAL];
  wire tx_en    = port_en && ctrl_reg[CB_TXEN];
  wire rx_en    = port_en && ctrl_reg[CB_RXEN];
  wire fifo_en  = ctrl_reg[CB_FIFOEN];
  wire ir_on    = ctrl_reg[CB_IREN];
  wire ir_lp    = ctrl_reg[CB_IREN] && ctrl_reg[CB_IRLP];
  wire [1:0] wlen     = line_reg[1:0];
  wire       stop_two = line_reg[2];
  wire [2:0] parity   = line_reg[5:3];

  // ---- Bus decode; strobes never overlap, except flush with wr_ctrl.
  wire wr_data = reg_wr && (reg_addr == OFS_DATA);
  wire wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
  wire wr_line = reg_wr && (reg_addr == OFS_LINE);
  wire wr_baud = reg_wr && (reg_addr == OFS_BAUD);
  wire wr_stat = reg_wr && (reg_addr == OFS_STAT);
  wire wr_ints = reg_wr && (reg_addr == OFS_INTS);
  wire wr_mask = reg_wr && (reg_addr == OFS_MASK);
  wire rd_data = reg_rd && (reg_addr == OFS_DATA);
  wire flush   = wr_ctrl && reg_wdata[CB_FLUSH];

  // ---- Bit rate: one tick per 1/16 bit; divisor 0 holds the line still.
  logic [15:0] bcnt_reg;
  wire tick = (baud_reg != 16'h0000) &&
              (bcnt_reg >= baud_reg - 16'h0001);

  always_ff @(posedge clock) begin
    if (!rst_b || tick || wr_baud) bcnt_reg <= 16'h0000;
    else bcnt_reg <= bcnt_reg + 16'h0001;
  end

  // ---- Pin synchronisers: three stages, a change counts once the
  // second and third stages agree.
  logic [2:0] srx_sync, irx_sync;
  logic       srx_reg, irx_reg;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      srx_sync <= 3'b111;
      irx_sync <= 3'b000;
      srx_reg  <= 1'b1;
      irx_reg  <= 1'b0;
    end else begin
      srx_sync <= {srx_sync[1:0], serial_rxd};
      irx_sync <= {irx_sync[1:0], ir_rxd};
      if (srx_sync[1] == srx_sync[2]) srx_reg <= srx_sync[2];
      if (irx_sync[1] == irx_sync[2]) irx_reg <= irx_sync[2];
    end
  end

  // ---- Infrared receive: a short high pulse means a zero bit; the
  // pulse is stretched over most of a bit so mid-bit sampling sees it.
  logic [3:0] irhold_reg;
  wire        ir_line = !(irx_reg || (irhold_reg != 4'h0));
  wire        rx_line = ir_on ? ir_line : srx_reg;

  always_ff @(posedge clock) begin
    if (!rst_b) irhold_reg <= 4'h0;
    else if (irx_reg) irhold_reg <= IR_HOLD_TICKS;
    else if (tick && irhold_reg != 4'h0) irhold_reg <= irhold_reg - 4'h1;
  end

  // ---- Transmit FIFO, 16 x 8.
  logic [TX_W-1:0] tx_mem [DEPTH];
  logic [PW-1:0]   txw_reg, txr_reg;
  logic [PW:0]     txc_reg;
  wire  [PW:0]     lim     = fifo_en ? DEPTH_C : ONE_C;
  wire             tx_full = (txc_reg >= lim);
  wire             tx_empt = (txc_reg == '0);
  wire             tx_busy;
  wire             tx_line;
  wire [3:0]       tx_phase;
  wire tx_push  = wr_data && !tx_full && !flush;
  wire tx_start = tx_en && !tx_busy && !tx_empt && !flush;

  always_ff @(posedge clock) begin
    if (tx_push) tx_mem[txw_reg] <= reg_wdata[TX_W-1:0];
  end

  // Flush only resets pointers and count; stale words are never read again.
  always_ff @(posedge clock) begin
    if (!rst_b || flush) begin
      txw_reg <= '0;
      txr_reg <= '0;
      txc_reg <= '0;
    end else begin
      if (tx_push) txw_reg <= ptr_inc(txw_reg);
      if (tx_start) txr_reg <= ptr_inc(txr_reg);
      txc_reg <= txc_reg + (tx_push ? ONE_C : '0) - (tx_start ? ONE_C : '0);
    end
  end

  uc_tx u_tx (
    .clock    (clock),
    .rst_b    (rst_b),
    .tick     (tick),
    .start    (tx_start),
    .data     (tx_mem[txr_reg]),
    .wlen     (wlen),
    .stop_two (stop_two),
    .parity   (parity),
    .busy     (tx_busy),
    .txd      (tx_line),
    .phase    (tx_phase)
  );

  // ---- Line outputs: NRZ when infrared is off, otherwise a pulse per
  // zero bit. Low power uses a fixed pulse of IR_LP_CYCLES clocks, whatever the divisor.
  logic [7:0] lp_cnt_reg;
  logic       stxd_reg, irtxd_reg;
  wire ir_win  = (tx_phase >= TICK_MID) && (tx_phase <= IR_PULSE_END);
  wire lp_load = tick && (tx_phase == TICK_MID) && !tx_line;
  wire ir_next = ir_on && !tx_line &&
                 (ir_lp ? (lp_cnt_reg != 8'h00) : ir_win);

  always_ff @(posedge clock) begin
    if (!rst_b) lp_cnt_reg <= 8'h00;
    else if (lp_load) lp_cnt_reg <= 8'(IR_LP_CYCLES);
    else if (lp_cnt_reg != 8'h00) lp_cnt_reg <= lp_cnt_reg - 8'h01;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stxd_reg  <= 1'b1;
      irtxd_reg <= 1'b0;
    end else begin
      stxd_reg  <= ir_on ? 1'b1 : tx_line;
      irtxd_reg <= ir_next;
    end
  end

  // ---- Receive FIFO, 16 x 12: {overrun, break, parity, frame, data}.
  logic [RX_W-1:0] rx_mem [DEPTH];
  logic [PW-1:0]   rxw_reg, rxr_reg;
  logic [PW:0]     rxc_reg;
  logic            ovpend_reg;
  wire             rx_done, rx_pe, rx_fe;
  wire [7:0]       rx_byte;
  wire             rx_full  = (rxc_reg >= lim);
  wire             rx_avail = (rxc_reg != '0);
  wire             rx_brk   = rx_fe && (rx_byte == 8'h00);
  wire             rx_push  = rx_done && !rx_full;
  wire             rx_ovr   = rx_done && rx_full;
  wire             rx_pop   = rd_data && rx_avail;

  uc_rx u_rx (
    .clock     (clock),
    .rst_b     (rst_b),
    .tick      (tick),
    .enable    (rx_en),
    .rxd       (rx_line),
    .wlen      (wlen),
    .parity    (parity),
    .done      (rx_done),
    .data      (rx_byte),
    .par_err   (rx_pe),
    .frame_err (rx_fe)
  );

  always_ff @(posedge clock) begin
    if (rx_push)
      rx_mem[rxw_reg] <= {ovpend_reg, rx_brk, rx_pe, rx_fe, rx_byte};
  end

  // A lost character marks the next one that does get stored.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rxw_reg    <= '0;
      rxr_reg    <= '0;
      rxc_reg    <= '0;
      ovpend_reg <= 1'b0;
    end else begin
      if (rx_push) rxw_reg <= ptr_inc(rxw_reg);
      if (rx_pop) rxr_reg <= ptr_inc(rxr_reg);
      rxc_reg <= rxc_reg + (rx_push ? ONE_C : '0) - (rx_pop ? ONE_C : '0);
      if (rx_ovr) ovpend_reg <= 1'b1;
      else if (rx_push) ovpend_reg <= 1'b0;
    end
  end

  // ---- DMA requests; the error latch blocks receive requests only
  // when stop-on-error is set.
  wire rx_err  = rx_done && (rx_pe || rx_fe || rx_full);
  wire dma_hlt = ctrl_reg[CB_ERRSTOP] && errseen_reg;
  assign rx_dma_req = ctrl_reg[CB_DMARX] && rx_avail && !dma_hlt;
  assign tx_dma_req = ctrl_reg[CB_DMATX] && tx_en && !tx_full;

  // ---- Interrupt events; a set in the clearing cycle wins.
  logic tx_empt_d;
  wire [4:0] ev;
  assign ev[EV_RX]      = rx_push;
  assign ev[EV_TXEMPTY] = tx_empt && !tx_empt_d;
  assign ev[EV_PARERR]  = rx_done && rx_pe;
  assign ev[EV_FRMERR]  = rx_done && rx_fe;
  assign ev[EV_OVERRUN] = rx_ovr;
  wire [4:0] ints_next  = (ints_reg & ~(wr_ints ? reg_wdata[4:0] : 5'h00)) | ev;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ints_reg    <= 5'h00;
      tx_empt_d   <= 1'b1;
      errseen_reg <= 1'b0;
    end else begin
      ints_reg    <= ints_next;
      tx_empt_d   <= tx_empt;
      errseen_reg <= rx_err || (errseen_reg && !(wr_stat && reg_wdata[5]));
    end
  end

  assign irq = |(ints_reg & mask_reg);

  // ---- Configuration writes; flush is a strobe and is not stored.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_reg <= CTRL_RST;
      line_reg <= LINE_RST;
      baud_reg <= BAUD_RST;
      mask_reg <= 5'h00;
    end else begin
      if (wr_ctrl) ctrl_reg <= reg_wdata[CB_ERRSTOP:0];
      if (wr_line) line_reg <= reg_wdata[5:0];
      if (wr_baud) baud_reg <= reg_wdata[15:0];
      if (wr_mask) mask_reg <= reg_wdata[4:0];
    end
  end

  // ---- Read mux; data reads pop the receive FIFO, empty reads flag
  // bit 15 so software can tell no character was there.
  wire [31:0] stat_w = {26'h0, errseen_reg, tx_busy, tx_empt, rx_full,
                        tx_full, rx_avail};
  wire [31:0] data_w = rx_avail ? {20'h0, rx_mem[rxr_reg]} : 32'h0000_8000;
  logic [31:0] rsel;

  always_comb begin
    case (reg_addr)
      OFS_DATA: rsel = data_w;
      OFS_CTRL: rsel = {23'h0, ctrl_reg};
      OFS_LINE: rsel = {26'h0, line_reg};
      OFS_BAUD: rsel = {16'h0, baud_reg};
      OFS_STAT: rsel = stat_w;
      OFS_INTS: rsel = {27'h0, ints_reg};
      OFS_MASK: rsel = {27'h0, mask_reg};
      default:  rsel = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) rdata_reg <= 32'h0000_0000;
    else rdata_reg <= reg_rd ? rsel : 32'h0000_0000;
  end

  assign reg_rdata  = rdata_reg;
  assign serial_txd = stxd_reg;
  assign ir_txd     = irtxd_reg;
endmodule // uc_uart

// [tb/uc_uart_sva.sv]
// Port checker for the serial port top, bound from the bench.
`timescale 1ns/1ns
module uc_uart_chk import uc_pkg::*; (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic [4:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        serial_rxd,
  input wire logic        ir_rxd,
  input wire logic        serial_txd,
  input wire logic        ir_txd,
  input wire logic        rx_dma_req,
  input wire logic        tx_dma_req,
  input wire logic        irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // A status read; then a data read right after it reported empty.
  sequence s_stat;
    reg_rd && reg_addr == OFS_STAT;
  endsequence
  sequence s_empty_pop;
    s_stat ##1 !reg_rdata[0] ##1 (reg_rd && reg_addr == OFS_DATA);
  endsequence

  property p_rd_idle;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("Read data stood without a read.");
  property p_empty_pop;
    s_empty_pop |=> reg_rdata == 32'h8000;
  endproperty
  a_empty_pop: assert property (p_empty_pop)
    else $error("Empty receive read gave a character.");
  property p_rx_dma;
    s_stat ##0 rx_dma_req |=> reg_rdata[0];
  endproperty
  a_rx_dma: assert property (p_rx_dma)
    else $error("Receive request with no data.");
  property p_tx_dma;
    s_stat ##0 tx_dma_req |=> !reg_rdata[1];
  endproperty
  a_tx_dma: assert property (p_tx_dma)
    else $error("Transmit request while full.");
  property p_reset_idle;
    $rose(rst_b) |-> serial_txd && !ir_txd && !rx_dma_req && !tx_dma_req && !irq;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("Outputs not idle after reset.");
  // Even the fastest divisor gives sixteen clocks per bit.
  property p_bit_hold;
    $changed(serial_txd) |=> $stable(serial_txd) [*8];
  endproperty
  a_bit_hold: assert property (p_bit_hold)
    else $error("Serial bit shorter than allowed.");
  property p_ir_quiet;
    ir_txd |-> serial_txd;
  endproperty
  a_ir_quiet: assert property (p_ir_quiet)
    else $error("Serial line moved in infrared mode.");
  property p_dma_off;
    reg_wr && reg_addr == OFS_CTRL && !reg_wdata[CB_DMARX] |=> !rx_dma_req;
  endproperty
  a_dma_off: assert property (p_dma_off)
    else $error("Receive request while disabled.");
endmodule // uc_uart_chk

// [tb/uc_remote.sv]
// Remote serial device: sends and captures NRZ frames.
`timescale 1ns/1ns
module uc_remote #(
  parameter int BIT = 16
) (
  input  wire logic clock,
  input  wire logic txd,
  output logic      rxd
);
  // The line has a pull-up, so it idles high between frames.
  initial rxd = 1'b1;

  task automatic put(input logic b);
    rxd <= b;
    repeat (BIT) @(posedge clock);
  endtask

  // Start low, data LSB first, parity, then stop bits high.
  task automatic send(input logic [7:0] x, input int nb, input bit hp,
                      input logic p, input bit two);
    put(1'b0);
    for (int j = 0; j < nb; j++) put(x[j]);
    if (hp) put(p);
    put(1'b1);
    if (two) put(1'b1);
  endtask

  // Samples mid-bit; the edge is seen one clock after the line fell.
  task automatic grab(input int nb, input bit hp, output logic [7:0] x,
                      output logic p, output logic s);
    int n;
    x = 8'h00;
    p = 1'b0;
    n = 0;
    while (txd !== 1'b0 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    // A start that never came returns unknowns, which the bench counts.
    if (n >= 3000) begin
      x = 8'hxx;
      p = 1'bx;
      s = 1'bx;
    end else begin
      repeat (BIT / 2 - 1) @(posedge clock);
      for (int j = 0; j < nb; j++) begin
        repeat (BIT) @(posedge clock);
        x[j] = txd;
      end
      if (hp) begin
        repeat (BIT) @(posedge clock);
        p = txd;
      end
      repeat (BIT) @(posedge clock);
      s = txd;
    end
  endtask
endmodule // uc_remote

// [tb/tb_top.sv]
// Self-checking bench for the serial port top.
`timescale 1ns/1ns
module tb_top import uc_pkg::*;;
  logic        clock, rst_b, reg_wr, reg_rd, ir_rxd, serial_rxd;
  logic        serial_txd, ir_txd, rx_dma_req, tx_dma_req, irq;
  logic        gp, gs, st;
  logic [1:0]  wl;
  logic [2:0]  pm;
  logic [4:0]  reg_addr;
  logic [7:0]  d, gd;
  logic [31:0] reg_wdata, reg_rdata, v;
  int          n_errors, total_checks, k, nh, np, nl, seed;

  uc_uart uut (
    .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .serial_rxd(serial_rxd), .ir_rxd(ir_rxd),
    .serial_txd(serial_txd), .ir_txd(ir_txd), .rx_dma_req(rx_dma_req),
    .tx_dma_req(tx_dma_req), .irq(irq)
  );
  uc_remote rem (.clock(clock), .txd(serial_txd), .rxd(serial_rxd));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic results();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] x);
    reg_addr <= a;
    reg_wdata <= x;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
    @(posedge clock);
  endtask

  task automatic wait_rx();
    for (int j = 0; j < 400; j++) begin
      rd(OFS_STAT, v);
      if (v[0]) break;
    end
    if (!v[0]) begin
      n_errors++;
      results();
    end
  endtask

  // Parity bit over the active data bits for each mode.
  function automatic logic pbit(input logic [7:0] x, input logic [1:0] w,
                                input logic [2:0] m);
    logic e;
    e = 1'b0;
    for (int j = 0; j < 5 + w; j++) e ^= x[j];
    case (m)
      3'h1: return e;
      3'h2: return ~e;
      3'h3: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 32'h0;
    ir_rxd = 1'b0;
    seed = $urandom(3368);
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rd(OFS_CTRL, v); chk("ctrl", v, 32'h0);
    rd(OFS_LINE, v); chk("line", v, 32'h3);
    rd(OFS_STAT, v); chk("stat", v, 32'h8);
    rd(OFS_DATA, v); chk("empty", v, 32'h8000);
    wr(OFS_BAUD, 32'h1);
    rd(OFS_BAUD, v); chk("baud", v, 32'h1);
    wr(OFS_CTRL, 32'hf);
    // Every word length and parity mode, random data and stop count.
    for (k = 0; k < 12; k++) begin
      wl = (k < 4) ? k[1:0] : 2'($urandom % 4);
      pm = 3'(k % 5);
      st = 1'($urandom % 2);
      d = 8'($urandom);
      wr(OFS_LINE, {26'h0, pm, st, wl});
      rd(OFS_LINE, v); chk("line", v, {26'h0, pm, st, wl});
      fork
        rem.grab(5 + wl, pm != 3'h0, gd, gp, gs);
        wr(OFS_DATA, {24'h0, d});
      join
      chk("txdata", gd, d & (8'hff >> (3 - wl)));
      chk("txpar", gp, (pm != 3'h0) ? pbit(d, wl, pm) : 1'b0);
      chk("txstop", gs, 1'b1);
      repeat (16) @(posedge clock);
      rd(OFS_STAT, v); chk("twostop", v[4], st);
      rem.send(d, 5 + wl, pm != 3'h0, pbit(d, wl, pm), st);
      wait_rx();
      rd(OFS_DATA, v); chk("rxdata", v, d & (8'hff >> (3 - wl)));
    end
    // Bad parity with and without the stop-on-error option.
    wr(OFS_LINE, {26'h0, parity_even_sel, 1'b0, word_length_eight});
    wr(OFS_MASK, 32'h4);
    for (k = 0; k < 2; k++) begin
      wr(OFS_CTRL, k ? 32'h4f : 32'h14f);
      d = 8'($urandom);
      rem.send(d, 8, 1'b1, ~pbit(d, 2'h3, parity_even_sel), 1'b0);
      wait_rx();
      chk("dmastop", rx_dma_req, k);
      chk("irq", irq, 1'b1);
      wr(OFS_STAT, 32'h20);
      rd(OFS_STAT, v); chk("dmago", rx_dma_req, 1'b1);
      rd(OFS_DATA, v); chk("rxerr", v, 32'h200 | d);
      wr(OFS_INTS, 32'h1f); chk("irqclr", irq, 1'b0);
    end
    // Fill the transmit FIFO with the transmitter off, then drain it.
    wr(OFS_CTRL, 32'h89);
    for (k = 0; k < 17; k++) begin
      if (k >= 15) begin
        rd(OFS_STAT, v); chk("full", v[1], k == 16);
      end
      wr(OFS_DATA, k);
    end
    wr(OFS_LINE, 32'h3);
    wr(OFS_CTRL, 32'h8b);
    for (k = 0; k < 16; k++) begin
      rem.grab(8, 1'b0, gd, gp, gs);
      chk("drain", gd, k);
    end
    repeat (16) @(posedge clock);
    rd(OFS_STAT, v); chk("dropped", v[4:0], 5'h08);
    chk("txdma", tx_dma_req, 1'b1);
    // Disable mid-frame, wait for idle, flush the queued rest.
    for (k = 0; k < 3; k++) wr(OFS_DATA, 32'h55);
    wr(OFS_CTRL, 32'h08);
    // Start as busy so the poll really runs; the frame is still going.
    v = 32'h10;
    for (k = 0; k < 300 && v[4] !== 1'b0; k++) rd(OFS_STAT, v);
    if (v[4] !== 1'b0) begin
      n_errors++;
      results();
    end
    chk("idle", serial_txd, 1'b1);
    wr(OFS_CTRL, 32'h208);
    rd(OFS_STAT, v); chk("flushed", v[3], 1'b1);
    // Infrared pulses, normal and low power, for an all-zero char.
    for (k = 0; k < 2; k++) begin
      wr(OFS_CTRL, k ? 32'h3f : 32'h1f);
      wr(OFS_DATA, 32'h0);
      nh = 0;
      np = 0;
      nl = 0;
      gp = 1'b0;
      repeat (200) begin
        @(posedge clock);
        if (ir_txd && !gp) np++;
        if (ir_txd) nh++;
        if (!serial_txd) nl++;
        gp = ir_txd;
      end
      chk("irpulses", np, 9);
      chk("irhigh", nh, k ? 72 : 27);
      chk("nrzquiet", nl, 0);
    end
    // Low power alone must leave the line in NRZ form.
    wr(OFS_CTRL, 32'h2f);
    fork
      rem.grab(8, 1'b0, gd, gp, gs);
      wr(OFS_DATA, 32'h5a);
    join
    chk("nrz", gd, 8'h5a);
    results();
  end
endmodule // tb_top

bind uc_uart uc_uart_chk chk (
  .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .serial_rxd(serial_rxd), .ir_rxd(ir_rxd),
  .serial_txd(serial_txd), .ir_txd(ir_txd), .rx_dma_req(rx_dma_req),
  .tx_dma_req(tx_dma_req), .irq(irq)
);
